// ===== logic/qpv_top.sv
// Quadrature position and velocity capture with an AHB-Lite register slave.
`timescale 1ns/1ns
module qpv_top (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic phase_a_input,
	input wire logic phase_b_input,
	input wire logic index_input,
	output logic irq
);

	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		qpv_pkg::qpv_bus_e bus;
		logic wr;
		logic [7:0] addr;
		logic [31:0] hrdata;
		logic [qpv_pkg::CTRL_W-1:0] ctrl;
		logic [31:0] position;
		logic [31:0] max_pos;
		logic [31:0] window;
		logic [31:0] timer;
		logic [31:0] accum;
		logic [31:0] velocity;
		logic [6:0] prediv_cnt;
		logic vel_en_d;
		logic direction;
		logic error;
		logic referenced;
		logic [qpv_pkg::INT_W-1:0] int_status;
		logic [qpv_pkg::INT_W-1:0] int_mask;
		logic irq;
	} qpv_s;

	qpv_s r;
	qpv_s next_r;

	qpv_step_if steps ();

	qpv_decoder u_decoder (
		.hclk(hclk),
		.hresetn(hresetn),
		.count_both_phases(r.ctrl[qpv_pkg::CTRL_BOTH_BIT]),
		.phase_a_input(phase_a_input),
		.phase_b_input(phase_b_input),
		.index_input(index_input),
		.steps(steps)
	);

	// ************************************************************
	// Combinational next state
	// ************************************************************
	logic enable;
	logic reset_on_index_mode;
	logic vel_en;
	logic [2:0] velocity_predivider;
	logic [6:0] div_mask;
	logic div_pulse;
	logic window_done;
	logic [qpv_pkg::INT_W-1:0] events;
	logic bus_start;
	logic rd_status;

	always_comb begin
		next_r = r;
		enable = r.ctrl[qpv_pkg::CTRL_ENABLE_BIT];
		reset_on_index_mode = r.ctrl[qpv_pkg::CTRL_RESET_IDX_BIT];
		vel_en = r.ctrl[qpv_pkg::CTRL_VEL_EN_BIT];
		velocity_predivider = r.ctrl[qpv_pkg::CTRL_PREDIV_LSB +: qpv_pkg::CTRL_PREDIV_W];
		div_mask = 7'((32'h1 << velocity_predivider) - 32'h1);
		div_pulse = 1'b0;
		window_done = 1'b0;
		events = '0;
		rd_status = 1'b0;

		// Position integrator.
		if (enable) begin
			if (steps.step) begin
				next_r.direction = steps.forward;
				if (steps.forward != r.direction) begin
					events[qpv_pkg::INT_DIR_BIT] = 1'b1;
				end
				if (steps.forward) begin
					next_r.position = (r.position >= r.max_pos) ? 32'h0 : r.position + 32'h1;
				end else begin
					next_r.position = (r.position == 32'h0) ? r.max_pos : r.position - 32'h1;
				end
			end
			if (steps.index_seen) begin
				events[qpv_pkg::INT_INDEX_BIT] = 1'b1;
				if (reset_on_index_mode) begin
					next_r.referenced = 1'b1;
					next_r.position = r.direction ? 32'h0 : r.max_pos;
				end
			end
			if (steps.error) begin
				next_r.error = 1'b1;
				events[qpv_pkg::INT_ERROR_BIT] = 1'b1;
			end
		end

		// Velocity capture; a window length of zero acts as a window of one.
		next_r.vel_en_d = vel_en;
		if (vel_en && !r.vel_en_d) begin
			next_r.accum = 32'h0;
			next_r.timer = 32'h0;
			next_r.prediv_cnt = 7'h0;
		end else if (vel_en && enable) begin
			if (steps.step) begin
				next_r.prediv_cnt = (r.prediv_cnt & div_mask) == div_mask ? 7'h0 : r.prediv_cnt + 7'h1;
				div_pulse = (r.prediv_cnt & div_mask) == div_mask;
			end
			window_done = (r.timer + 32'h1) >= r.window;
			if (window_done) begin
				next_r.velocity = r.accum + {31'h0, div_pulse};
				next_r.accum = 32'h0;
				next_r.timer = 32'h0;
				events[qpv_pkg::INT_TIMER_BIT] = 1'b1;
			end else begin
				next_r.accum = r.accum + {31'h0, div_pulse};
				next_r.timer = r.timer + 32'h1;
			end
		end

		// AHB-Lite slave: zero wait states, response always OKAY.
		bus_start = hsel && hready && htrans[1];
		if (r.bus == qpv_pkg::QPV_BUS_DATA) begin
			if (r.wr) begin
				if (r.addr == qpv_pkg::ADDR_CTRL) begin
					next_r.ctrl = hwdata[qpv_pkg::CTRL_W-1:0];
				end else if (r.addr == qpv_pkg::ADDR_POSITION) begin
					next_r.position = hwdata;
				end else if (r.addr == qpv_pkg::ADDR_MAX_POS) begin
					next_r.max_pos = hwdata;
				end else if (r.addr == qpv_pkg::ADDR_WINDOW) begin
					next_r.window = hwdata;
				end else if (r.addr == qpv_pkg::ADDR_STATUS) begin
					// A new error in the same cycle as the clear wins over it.
					next_r.error = (r.error & ~hwdata[qpv_pkg::ST_ERR_BIT]) | (enable & steps.error);
				end else if (r.addr == qpv_pkg::ADDR_INT_MASK) begin
					next_r.int_mask = hwdata[qpv_pkg::INT_W-1:0];
				end
			end else if (r.addr == qpv_pkg::ADDR_INT_STATUS) begin
				rd_status = 1'b1;
			end
		end
		next_r.bus = bus_start ? qpv_pkg::QPV_BUS_DATA : qpv_pkg::QPV_BUS_IDLE;
		next_r.wr = bus_start && hwrite;
		next_r.addr = haddr[7:0];
		next_r.hrdata = 32'h0;
		if (bus_start && !hwrite) begin
			if (haddr[7:0] == qpv_pkg::ADDR_CTRL) begin
				next_r.hrdata = {25'h0, r.ctrl};
			end else if (haddr[7:0] == qpv_pkg::ADDR_POSITION) begin
				next_r.hrdata = r.position;
			end else if (haddr[7:0] == qpv_pkg::ADDR_MAX_POS) begin
				next_r.hrdata = r.max_pos;
			end else if (haddr[7:0] == qpv_pkg::ADDR_WINDOW) begin
				next_r.hrdata = r.window;
			end else if (haddr[7:0] == qpv_pkg::ADDR_VELOCITY) begin
				next_r.hrdata = r.velocity;
			end else if (haddr[7:0] == qpv_pkg::ADDR_STATUS) begin
				next_r.hrdata = {29'h0, r.referenced, r.error, r.direction};
			end else if (haddr[7:0] == qpv_pkg::ADDR_INT_STATUS) begin
				next_r.hrdata = {28'h0, r.int_status};
			end else if (haddr[7:0] == qpv_pkg::ADDR_INT_MASK) begin
				next_r.hrdata = {28'h0, r.int_mask};
			end else if (haddr[7:0] == qpv_pkg::ADDR_ACCUM) begin
				next_r.hrdata = r.accum;
			end
		end

		// Sticky interrupt status: a new event wins over the clear by read.
		// Only the bits that the read returned are cleared, so an event during the address phase survives.
		next_r.int_status = (rd_status ? (r.int_status & ~r.hrdata[qpv_pkg::INT_W-1:0]) : r.int_status) | events;
		next_r.irq = |(next_r.int_status & r.int_mask);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r <= '0;
			r.ctrl <= qpv_pkg::RESET_CTRL;
			r.max_pos <= qpv_pkg::RESET_MAX_POS;
			r.window <= qpv_pkg::RESET_WINDOW;
			r.direction <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	assign hrdata = r.hrdata;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign irq = r.irq;
endmodule // qpv_top

// ===== logic/qpv_pkg.sv
// Package of constants and types for the quadrature position and velocity block.
package qpv_pkg;

	// ************************************************************
	// Register map
	// ************************************************************
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_POSITION = 8'h04;
	localparam logic [7:0] ADDR_MAX_POS = 8'h08;
	localparam logic [7:0] ADDR_WINDOW = 8'h0C;
	localparam logic [7:0] ADDR_VELOCITY = 8'h10;
	localparam logic [7:0] ADDR_STATUS = 8'h14;
	localparam logic [7:0] ADDR_INT_STATUS = 8'h18;
	localparam logic [7:0] ADDR_INT_MASK = 8'h1C;
	localparam logic [7:0] ADDR_ACCUM = 8'h20;

	// ************************************************************
	// Control fields
	// ************************************************************
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_BOTH_BIT = 1;
	localparam int CTRL_RESET_IDX_BIT = 2;
	localparam int CTRL_VEL_EN_BIT = 3;
	localparam int CTRL_PREDIV_LSB = 4;
	localparam int CTRL_PREDIV_W = 3;
	localparam int CTRL_W = 7;

	// ************************************************************
	// Status and interrupt fields
	// ************************************************************
	localparam int ST_DIR_BIT = 0;
	localparam int ST_ERR_BIT = 1;
	localparam int ST_REFERENCED_BIT = 2;
	localparam int INT_ERROR_BIT = 0;
	localparam int INT_DIR_BIT = 1;
	localparam int INT_TIMER_BIT = 2;
	localparam int INT_INDEX_BIT = 3;
	localparam int INT_W = 4;

	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic [31:0] RESET_MAX_POS = 32'hFFFF_FFFF;
	localparam logic [31:0] RESET_WINDOW = 32'h0000_0001;
	localparam logic [CTRL_W-1:0] RESET_CTRL = 7'h00;

	// ************************************************************
	// Bus state machine
	// ************************************************************
	typedef enum logic [0:0] {
		QPV_BUS_IDLE = 1'b0,
		QPV_BUS_DATA = 1'b1
	} qpv_bus_e;

endpackage

// ===== logic/qpv_step_if.sv
// Interface that carries decoded encoder steps from the decoder to the top.
`timescale 1ns/1ns
interface qpv_step_if;
	logic step;
	logic forward;
	logic index_seen;
	logic error;
	modport src (output step, output forward, output index_seen, output error);
	modport dst (input step, input forward, input index_seen, input error);
endinterface

// ===== logic/qpv_decoder.sv
// Synchroniser and quadrature edge decoder.
`timescale 1ns/1ns
module qpv_decoder (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic count_both_phases,
	input wire logic phase_a_input,
	input wire logic phase_b_input,
	input wire logic index_input,
	qpv_step_if.src steps
);
	typedef struct packed {
		logic [2:0] a_sync;
		logic [2:0] b_sync;
		logic [2:0] i_sync;
		logic a;
		logic b;
		logic i;
		logic step;
		logic forward;
		logic index_seen;
		logic error;
	} qpv_dec_s;

	qpv_dec_s r;
	qpv_dec_s next_r;

	always_comb begin
		next_r = r;
		next_r.a_sync = {r.a_sync[1:0], phase_a_input};
		next_r.b_sync = {r.b_sync[1:0], phase_b_input};
		next_r.i_sync = {r.i_sync[1:0], index_input};
		// A change counts only once the second and third stages agree.
		if (r.a_sync[1] == r.a_sync[2]) begin
			next_r.a = r.a_sync[2];
		end
		if (r.b_sync[1] == r.b_sync[2]) begin
			next_r.b = r.b_sync[2];
		end
		if (r.i_sync[1] == r.i_sync[2]) begin
			next_r.i = r.i_sync[2];
		end
		next_r.step = 1'b0;
		next_r.error = 1'b0;
		next_r.index_seen = next_r.i & ~r.i;
		if ((next_r.a != r.a) && (next_r.b != r.b)) begin
			next_r.error = 1'b1;
		end else if (next_r.a != r.a) begin
			next_r.step = 1'b1;
			next_r.forward = next_r.a ^ r.b;
		end else if ((next_r.b != r.b) && count_both_phases) begin
			next_r.step = 1'b1;
			next_r.forward = ~(next_r.b ^ r.a);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign steps.step = r.step;
	assign steps.forward = r.forward;
	assign steps.index_seen = r.index_seen;
	assign steps.error = r.error;
endmodule // qpv_decoder

// ===== tb/qpv_checker.sv
// Port checker for the quadrature position and velocity block.
`timescale 1ns/1ns
module qpv_checker (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic irq
);
	logic rd_dp, wr_dp, any_dp;
	logic [7:0] dp_a;
	logic [31:0] max_sh, win_sh, msk_sh, ctl_sh;
	assign any_dp = rd_dp | wr_dp;
	// Shadows follow software writes only, since hardware never alters these registers.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_dp <= 1'b0;
			wr_dp <= 1'b0;
			dp_a <= 8'h00;
			max_sh <= qpv_pkg::RESET_MAX_POS;
			win_sh <= qpv_pkg::RESET_WINDOW;
			msk_sh <= 32'h0000_0000;
			ctl_sh <= 32'h0000_0000;
		end else begin
			rd_dp <= hsel & hready & htrans[1] & !hwrite;
			wr_dp <= hsel & hready & htrans[1] & hwrite;
			dp_a <= haddr[7:0];
			if (wr_dp && dp_a == qpv_pkg::ADDR_MAX_POS) max_sh <= hwdata;
			if (wr_dp && dp_a == qpv_pkg::ADDR_WINDOW) win_sh <= hwdata;
			if (wr_dp && dp_a == qpv_pkg::ADDR_INT_MASK) msk_sh <= hwdata;
			if (wr_dp && dp_a == qpv_pkg::ADDR_CTRL) ctl_sh <= hwdata;
		end
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	ready_always_a: assert property (hreadyout) else $error("ready low");
	resp_okay_a: assert property (!hresp) else $error("resp error");
	rdata_quiet_a: assert property (!rd_dp |-> hrdata == 32'h0000_0000) else $error("stray rdata");
	unmapped_zero_a: assert property (rd_dp && dp_a > qpv_pkg::ADDR_ACCUM |-> hrdata == 32'h0000_0000)
		else $error("unmapped data");
	max_read_a: assert property (rd_dp && dp_a == qpv_pkg::ADDR_MAX_POS |-> hrdata == $past(max_sh))
		else $error("max readback");
	window_read_a: assert property (rd_dp && dp_a == qpv_pkg::ADDR_WINDOW |-> hrdata == $past(win_sh))
		else $error("window readback");
	ctrl_read_a: assert property (rd_dp && dp_a == qpv_pkg::ADDR_CTRL |-> hrdata[6:0] == $past(ctl_sh[6:0]))
		else $error("ctrl readback");
	irq_masked_a: assert property (msk_sh[3:0] == 4'h0 && $past(msk_sh[3:0]) == 4'h0 |-> !irq) else $error("irq masked");
	irq_fall_cause_a: assert property ($fell(irq) |-> $past(any_dp) || $past(any_dp, 2) || $past(any_dp, 3))
		else $error("irq fell alone");
	irq_c: cover property ($rose(irq));
	vel_c: cover property (rd_dp && dp_a == qpv_pkg::ADDR_VELOCITY);
	pos_c: cover property (wr_dp && dp_a == qpv_pkg::ADDR_POSITION);
endmodule // qpv_checker

// ===== tb/qpv_enc_model.sv
// Behavioural incremental encoder with an index pulse.
`timescale 1ns/1ns
module qpv_enc_model (
	input wire logic hclk,
	output logic phase_a_input,
	output logic phase_b_input,
	output logic index_input
);
	initial begin
		phase_a_input = 1'b0;
		phase_b_input = 1'b0;
		index_input = 1'b0;
	end
	// Phase A leads when moving forward; one phase changes per step.
	task automatic move(input logic fwd, input int gap);
		if ((phase_a_input == phase_b_input) == fwd) phase_a_input <= ~phase_a_input;
		else phase_b_input <= ~phase_b_input;
		repeat (gap) @(posedge hclk);
	endtask
	task automatic glitch();
		phase_a_input <= ~phase_a_input;
		phase_b_input <= ~phase_b_input;
		repeat (8) @(posedge hclk);
	endtask
	task automatic pulse_index();
		index_input <= 1'b1;
		repeat (8) @(posedge hclk);
		index_input <= 1'b0;
		repeat (8) @(posedge hclk);
	endtask
endmodule // qpv_enc_model

// ===== tb/testbench.sv
// Self-checking bench for the quadrature position and velocity block.
`timescale 1ns/1ns
module testbench;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0] htrans = 2'b00;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'b010;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [31:0] hrdata, p0;
	logic hreadyout, hresp, irq, pa, pb, pi;
	logic taken = 1'b0;
	logic run = 1'b1;
	logic [31:0] exp_q[$], msk_q[$];
	logic [7:0] adr_q[$];
	int err_count = 0;
	int check_count = 0;
	int cycles = 0;
	int seed = 32'h68a2;
	int tn = 0;
	always #2 hclk = ~hclk;
	qpv_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.phase_a_input(pa), .phase_b_input(pb), .index_input(pi), .irq(irq));
	qpv_enc_model u_enc (.hclk(hclk), .phase_a_input(pa), .phase_b_input(pb), .index_input(pi));
	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
		check_count++;
		if (s !== e) begin
			err_count++;
			$display("unexpected %s exp %h seen %h", nm, e, s);
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// Read data stands for the data phase only, so it is taken at the edge that ends it.
	always @(posedge hclk) begin
		if (taken) begin
			cmp($sformatf("reg_%h", adr_q.pop_front()), exp_q.pop_front(), hrdata & msk_q.pop_front());
		end
		taken <= hsel & hreadyout & htrans[1] & !hwrite;
		cycles++;
		if (cycles == 40000) begin
			err_count++;
			final_report();
		end
	end
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h00_0000, a};
		hwrite <= w;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		adr_q.push_back(a);
		exp_q.push_back(e & m);
		msk_q.push_back(m);
		bus(1'b0, a, $random(seed));
	endtask
	task automatic mv(input logic f, input int n);
		repeat (n) u_enc.move(f, 5 + ($random(seed) & 7));
		repeat (10) @(posedge hclk);
	endtask
	task automatic tdone();
		tn++;
		$display("test %0d done", tn);
	endtask
	function automatic logic [31:0] cv(input logic [3:0] f, input logic [2:0] p);
		return {25'h000_0000, p, f};
	endfunction
	initial begin
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(qpv_pkg::ADDR_CTRL, 32'h0000_0000, 32'hFFFF_FFFF);
		rd(qpv_pkg::ADDR_MAX_POS, 32'hFFFF_FFFF, 32'hFFFF_FFFF);
		rd(qpv_pkg::ADDR_WINDOW, 32'h0000_0001, 32'hFFFF_FFFF);
		tdone();
		wr(qpv_pkg::ADDR_CTRL, cv(4'h3, 3'h0));
		p0 = $random(seed);
		wr(qpv_pkg::ADDR_POSITION, p0);
		mv(1'b1, 5);
		rd(qpv_pkg::ADDR_POSITION, p0 + 5, 32'hFFFF_FFFF);
		mv(1'b0, 7);
		rd(qpv_pkg::ADDR_POSITION, p0 - 2, 32'hFFFF_FFFF);
		wr(qpv_pkg::ADDR_CTRL, cv(4'h1, 3'h0));
		mv(1'b1, 4);
		rd(qpv_pkg::ADDR_POSITION, p0, 32'hFFFF_FFFF);
		wr(qpv_pkg::ADDR_CTRL, cv(4'h3, 3'h0));
		wr(qpv_pkg::ADDR_MAX_POS, 32'h0000_0009);
		wr(qpv_pkg::ADDR_POSITION, 32'h0000_0009);
		mv(1'b1, 1);
		rd(qpv_pkg::ADDR_POSITION, 32'h0000_0000, 32'hFFFF_FFFF);
		mv(1'b0, 1);
		rd(qpv_pkg::ADDR_POSITION, 32'h0000_0009, 32'hFFFF_FFFF);
		tdone();
		wr(qpv_pkg::ADDR_CTRL, cv(4'h7, 3'h0));
		mv(1'b1, 1);
		rd(qpv_pkg::ADDR_STATUS, 32'h0000_0000, 32'h0000_0004);
		wr(qpv_pkg::ADDR_POSITION, 32'h0000_0005);
		u_enc.pulse_index();
		rd(qpv_pkg::ADDR_POSITION, 32'h0000_0000, 32'hFFFF_FFFF);
		rd(qpv_pkg::ADDR_STATUS, 32'h0000_0004, 32'h0000_0004);
		mv(1'b1, 3);
		mv(1'b0, 1);
		u_enc.pulse_index();
		rd(qpv_pkg::ADDR_POSITION, 32'h0000_0009, 32'hFFFF_FFFF);
		wr(qpv_pkg::ADDR_CTRL, cv(4'h3, 3'h0));
		wr(qpv_pkg::ADDR_POSITION, 32'h0000_0004);
		u_enc.pulse_index();
		rd(qpv_pkg::ADDR_POSITION, 32'h0000_0004, 32'hFFFF_FFFF);
		tdone();
		wr(qpv_pkg::ADDR_INT_MASK, 32'h0000_0001);
		u_enc.glitch();
		repeat (4) @(posedge hclk);
		cmp("irq", 32'h0000_0001, {31'h0000_0000, irq});
		rd(qpv_pkg::ADDR_STATUS, 32'h0000_0002, 32'h0000_0002);
		rd(qpv_pkg::ADDR_INT_STATUS, 32'h0000_0001, 32'h0000_0001);
		repeat (4) @(posedge hclk);
		cmp("irq", 32'h0000_0000, {31'h0000_0000, irq});
		rd(qpv_pkg::ADDR_INT_STATUS, 32'h0000_0000, 32'h0000_0001);
		wr(qpv_pkg::ADDR_STATUS, 32'h0000_0002);
		rd(qpv_pkg::ADDR_STATUS, 32'h0000_0000, 32'h0000_0002);
		rd(qpv_pkg::ADDR_POSITION, 32'h0000_0004, 32'hFFFF_FFFF);
		wr(qpv_pkg::ADDR_INT_MASK, 32'h0000_0000);
		u_enc.glitch();
		repeat (4) @(posedge hclk);
		cmp("irq", 32'h0000_0000, {31'h0000_0000, irq});
		rd(8'h40, 32'h0000_0000, 32'hFFFF_FFFF);
		tdone();
		// Steps every four cycles give exactly 128 steps in a 512 cycle window.
		fork
			while (run) u_enc.move(1'b1, 4);
		join_none
		for (int p = 0; p < 8; p++) begin
			wr(qpv_pkg::ADDR_CTRL, cv(4'h3, p[2:0]));
			wr(qpv_pkg::ADDR_WINDOW, 32'h0000_0200);
			wr(qpv_pkg::ADDR_CTRL, cv(4'hB, p[2:0]));
			repeat (1100) @(posedge hclk);
			rd(qpv_pkg::ADDR_VELOCITY, 32'h0000_0080 >> p, 32'hFFFF_FFFF);
		end
		// Steps keep coming at an undivided rate, so an ungated accumulator would show 128 here.
		wr(qpv_pkg::ADDR_CTRL, cv(4'h3, 3'h0));
		repeat (1100) @(posedge hclk);
		rd(qpv_pkg::ADDR_VELOCITY, 32'h0000_0001, 32'hFFFF_FFFF);
		run = 1'b0;
		tdone();
		final_report();
	end
endmodule // testbench
bind qpv_top qpv_checker u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq));
